// ==== rtl/biphase_rx_pkg.sv ====
// Constants shared by the biphase receiver status and rate monitor.
package biphase_rx_pkg;
  localparam int CLK_HZ = 40000000;
  localparam int CLK_MHZ = CLK_HZ / 1000000;
  localparam int REF_HZ = 24576000;
  // Reference counted as stopped after this long without an edge.
  localparam int REF_TMO_NS = 2000;
  localparam int REF_TMO_CYC = (REF_TMO_NS * CLK_MHZ + 999) / 1000;
  // Rate windows in Hz.
  localparam int FS32_LO_HZ = 31200;
  localparam int FS32_HI_HZ = 32800;
  localparam int FS44_LO_HZ = 43000;
  localparam int FS44_HI_HZ = 45200;
  localparam int FS48_LO_HZ = 46800;
  localparam int FS48_HI_HZ = 49200;
  // Reference edges per frame for each window.
  localparam int CNT32_MIN = (REF_HZ + FS32_HI_HZ - 1) / FS32_HI_HZ;
  localparam int CNT32_MAX = REF_HZ / FS32_LO_HZ;
  localparam int CNT44_MIN = (REF_HZ + FS44_HI_HZ - 1) / FS44_HI_HZ;
  localparam int CNT44_MAX = REF_HZ / FS44_LO_HZ;
  localparam int CNT48_MIN = (REF_HZ + FS48_HI_HZ - 1) / FS48_HI_HZ;
  localparam int CNT48_MAX = REF_HZ / FS48_LO_HZ;
  // Rate codes, bit 1 then bit 0.
  localparam logic [1:0] RATE_LL = 2'h0;
  localparam logic [1:0] RATE_LH = 2'h1;
  localparam logic [1:0] RATE_HL = 2'h2;
  localparam logic [1:0] RATE_HH = 2'h3;
  // Clock source modes.
  localparam logic [1:0] MODE_REC = 2'h0;
  localparam logic [1:0] MODE_REF = 2'h1;
  localparam logic [1:0] MODE_AUTO = 2'h2;
  // Frame counts and status bit frame indices.
  localparam int LOCK_FRAMES = 4;
  localparam int BLOCK_PULSE_FRAMES = 8;
  localparam int NPCM_IDX = 1;
  localparam int EMPHASIS_IDX = 3;
  // Register map.
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [7:0] ADR_MEAS = 8'h08;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_MODE_LSB = 0;
  localparam int STAT_RATE_LSB = 0;
  localparam int STAT_SEEN = 2;
  localparam int STAT_ACT = 3;
  localparam int STAT_LOCK = 4;
  localparam int STAT_ERR = 5;
  localparam int STAT_NPCM = 6;
  localparam int STAT_EMPHASIS = 7;
  localparam int STAT_SRC_REF = 8;
endpackage : biphase_rx_pkg

// ==== rtl/biphase_rx_status_fs_monitor.sv ====
// Status flags, lock and error reporting, rate measurement and clock source.
//
// Summary of operation
// - Non-PCM flag follows status bit 1.
// - Emphasis flag follows status bit 3.
// - Flags come from left channel only.
// - Flags load only at block start and are held clear while unlocked.
// - Coding or length violation drops lock.
// - Missing preamble drops lock.
// - Error high when unlocked or parity error.
// - Error rises with transition, falls on frame.
// - PCM parity error repeats previous sample.
// - Non-PCM parity error passes data unchanged.
// - Rate measured by counting reference clock.
// - Grounded reference means no measurement.
// - No reference ever seen gives code LL.
// - Rate code never from status bits.
// - Windows map to HH, LL, LH.
// - Unlocked or out of range gives HL.
// - Stopped reference holds last result.
// - Three modes chosen by clock select.
// - Auto mode follows error output.
// - Reference mode mutes recovered data.
// - Reference mode without reference: no clocks.
// - Status outputs stay active in reference mode.
// - Reference mode clocks derive from reference.
`timescale 1ns/100ps
module biphase_rx_status_fs_monitor #(
  parameter int LOCK_FRAMES = biphase_rx_pkg::LOCK_FRAMES,
  parameter int CNT_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic reference_clock_in_i,
  input wire logic pll_lock_i,
  input wire logic frame_stb_i,
  input wire logic left_i,
  input wire logic block_i,
  input wire logic cs_bit_i,
  input wire logic parity_err_i,
  input wire logic coding_err_i,
  input wire logic preamble_err_i,
  input wire logic [23:0] sample_i,
  output logic [23:0] sample_o,
  output logic sample_valid_o,
  output logic sample_left_o,
  output logic nonpcm_flag_o,
  output logic emphasis_flag_out_o,
  output logic error_o,
  output logic clock_transition_pulse_o,
  output logic block_start_out_o,
  output logic [1:0] rate_code_out_o,
  output logic clk_src_ref_o,
  output logic clk_out_en_o,
  output logic frame_rate_clock_o,
  output logic ref_bit_clock_o
);

  localparam logic [7:0] TMO = 8'(biphase_rx_pkg::REF_TMO_CYC);
  localparam logic [3:0] LOCK_LAST = 4'(LOCK_FRAMES - 1);

  function automatic logic [1:0] classify(input logic [CNT_W-1:0] c);
    if (c >= CNT_W'(biphase_rx_pkg::CNT32_MIN) && c <= CNT_W'(biphase_rx_pkg::CNT32_MAX)) begin
      classify = biphase_rx_pkg::RATE_HH;
    end else if (c >= CNT_W'(biphase_rx_pkg::CNT44_MIN)
                 && c <= CNT_W'(biphase_rx_pkg::CNT44_MAX)) begin
      classify = biphase_rx_pkg::RATE_LL;
    end else if (c >= CNT_W'(biphase_rx_pkg::CNT48_MIN)
                 && c <= CNT_W'(biphase_rx_pkg::CNT48_MAX)) begin
      classify = biphase_rx_pkg::RATE_LH;
    end else begin
      classify = biphase_rx_pkg::RATE_HL;
    end
  endfunction : classify

  logic ref_s1_r, ref_s2_r, ref_s3_r;
  logic lock_s1_r, lock_s2_r;
  logic ref_edge, ref_act, fstb_l, blk_take, bad;
  logic [7:0] ref_idle_r;
  logic ref_seen_r;
  logic [CNT_W-1:0] meas_cnt_r, meas_last_r;
  logic meas_ok_r;
  logic [1:0] rate_r;
  logic lock_r, lock_nxt;
  logic [3:0] good_r;
  logic ct_r, err_r, err_nxt, par_seen_r;
  logic [7:0] fidx_r, cur_idx;
  logic sh_npcm_r, sh_emphasis_r, nonpcm_r, emphasis_r;
  logic [3:0] bpulse_r;
  logic [23:0] hold_l_r, hold_rt_r, sample_r, pick;
  logic valid_r, sleft_r, mute;
  logic [1:0] mode_r;
  logic use_ref;
  logic [7:0] ref_div_r;
  logic rec_fclk_r, fclk_r, bclk_r;
  logic ack_r;
  logic [31:0] rdat, dat_r;

  // Pins from other domains pass two flops first.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
    end else if (ce_i) begin
      ref_s1_r <= reference_clock_in_i;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      lock_s1_r <= pll_lock_i;
      lock_s2_r <= lock_s1_r;
    end
  end

  assign ref_edge = ref_s2_r & ~ref_s3_r;
  assign ref_act = ref_idle_r < TMO;
  assign fstb_l = frame_stb_i & left_i;
  assign blk_take = fstb_l & block_i;
  assign cur_idx = block_i ? 8'h00 : fidx_r;

  // Grounded reference never counts as present.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_idle_r <= TMO;
      ref_seen_r <= 1'b0;
      ref_div_r <= 8'h00;
    end else if (ce_i) begin
      if (ref_edge) begin
        ref_idle_r <= 8'h00;
        ref_seen_r <= 1'b1;
        ref_div_r <= ref_div_r + 8'h01;
      end else if (ref_idle_r < TMO) begin
        ref_idle_r <= ref_idle_r + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_cnt_r <= '0;
      meas_last_r <= '0;
      meas_ok_r <= 1'b0;
      rate_r <= biphase_rx_pkg::RATE_HL;
    end else if (ce_i) begin
      if (fstb_l) begin
        meas_cnt_r <= ref_edge ? CNT_W'(1) : '0;
        meas_ok_r <= ref_act;
        if (ref_act && meas_ok_r) begin
          meas_last_r <= meas_cnt_r;
          rate_r <= classify(meas_cnt_r);
        end
      end else if (!ref_act) begin
        meas_ok_r <= 1'b0;
      end else if (ref_edge && meas_cnt_r != '1) begin
        meas_cnt_r <= meas_cnt_r + CNT_W'(1);
      end
    end
  end

  // No reference since reset gives LL.
  always_comb begin
    if (!ref_seen_r) begin
      rate_code_out_o = biphase_rx_pkg::RATE_LL;
    end else if (!lock_r) begin
      rate_code_out_o = biphase_rx_pkg::RATE_HL;
    end else begin
      rate_code_out_o = rate_r;
    end
  end

  assign bad = coding_err_i | preamble_err_i | ~lock_s2_r;

  always_comb begin
    lock_nxt = lock_r;
    if (bad) begin
      lock_nxt = 1'b0;
    end else if (fstb_l && good_r == LOCK_LAST) begin
      lock_nxt = 1'b1;
    end
  end

  // Error is unlock or parity fault.
  always_comb begin
    err_nxt = err_r;
    if (!lock_nxt || (frame_stb_i && parity_err_i)) begin
      err_nxt = 1'b1;
    // Falls only on a frame edge.
    end else if (fstb_l && !par_seen_r) begin
      err_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_r <= 1'b0;
      good_r <= 4'h0;
      ct_r <= 1'b0;
      err_r <= 1'b1;
      par_seen_r <= 1'b0;
    end else if (ce_i) begin
      lock_r <= lock_nxt;
      if (bad || lock_r) begin
        good_r <= 4'h0;
      end else if (fstb_l && good_r != LOCK_LAST) begin
        good_r <= good_r + 4'h1;
      end
      // Transition pulse and error rise share an edge.
      ct_r <= lock_nxt != lock_r;
      err_r <= err_nxt;
      if (frame_stb_i && parity_err_i) begin
        par_seen_r <= 1'b1;
      end else if (fstb_l) begin
        par_seen_r <= 1'b0;
      end
    end
  end

  // Status capture on left frames only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fidx_r <= 8'h00;
      sh_npcm_r <= 1'b0;
      sh_emphasis_r <= 1'b0;
      nonpcm_r <= 1'b0;
      emphasis_r <= 1'b0;
      bpulse_r <= 4'h0;
    end else if (ce_i) begin
      if (fstb_l) begin
        fidx_r <= cur_idx + 8'h01;
        if (cur_idx == 8'(biphase_rx_pkg::NPCM_IDX)) begin
          sh_npcm_r <= cs_bit_i;
        end
        if (cur_idx == 8'(biphase_rx_pkg::EMPHASIS_IDX)) begin
          sh_emphasis_r <= cs_bit_i;
        end
        if (block_i) begin
          bpulse_r <= 4'(biphase_rx_pkg::BLOCK_PULSE_FRAMES);
        end else if (bpulse_r != 4'h0) begin
          bpulse_r <= bpulse_r - 4'h1;
        end
      end
      if (!lock_nxt) begin
        nonpcm_r <= 1'b0;
        emphasis_r <= 1'b0;
      // While locked, outputs move only at block start.
      end else if (blk_take) begin
        nonpcm_r <= sh_npcm_r;
        emphasis_r <= sh_emphasis_r;
      end
    end
  end

  // Recovered data muted in reference source.
  assign mute = use_ref | ~lock_r;

  always_comb begin
    pick = sample_i;
    // PCM parity fault repeats last good sample.
    if (parity_err_i && !nonpcm_r) begin
      pick = left_i ? hold_l_r : hold_rt_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_l_r <= 24'h000000;
      hold_rt_r <= 24'h000000;
      sample_r <= 24'h000000;
      valid_r <= 1'b0;
      sleft_r <= 1'b0;
    end else if (ce_i) begin
      valid_r <= frame_stb_i;
      if (frame_stb_i) begin
        sleft_r <= left_i;
        sample_r <= mute ? 24'h000000 : pick;
        if (!parity_err_i && left_i) begin
          hold_l_r <= sample_i;
        end
        if (!parity_err_i && !left_i) begin
          hold_rt_r <= sample_i;
        end
      end
    end
  end

  // Mode set by the clock select field.
  // Auto mode steered by error state.
  always_comb begin
    case (mode_r)
      biphase_rx_pkg::MODE_REF: use_ref = 1'b1;
      biphase_rx_pkg::MODE_AUTO: use_ref = err_r;
      default: use_ref = 1'b0;
    endcase
  end

  assign clk_out_en_o = ~use_ref | ref_act;

  // Reference clocks divided from reference edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rec_fclk_r <= 1'b0;
      fclk_r <= 1'b0;
      bclk_r <= 1'b0;
    end else if (ce_i) begin
      if (frame_stb_i) begin
        rec_fclk_r <= left_i;
      end
      if (!clk_out_en_o) begin
        fclk_r <= 1'b0;
        bclk_r <= 1'b0;
      end else begin
        fclk_r <= use_ref ? ref_div_r[7] : rec_fclk_r;
        bclk_r <= use_ref & ref_div_r[1];
      end
    end
  end

  always_comb begin
    rdat = 32'h00000000;
    case (wb_adr_i)
      biphase_rx_pkg::ADR_CTRL: rdat[biphase_rx_pkg::CTRL_MODE_LSB +: 2] = mode_r;
      biphase_rx_pkg::ADR_STAT: begin
        rdat[biphase_rx_pkg::STAT_RATE_LSB +: 2] = rate_code_out_o;
        rdat[biphase_rx_pkg::STAT_SEEN] = ref_seen_r;
        rdat[biphase_rx_pkg::STAT_ACT] = ref_act;
        rdat[biphase_rx_pkg::STAT_LOCK] = lock_r;
        rdat[biphase_rx_pkg::STAT_ERR] = err_r;
        rdat[biphase_rx_pkg::STAT_NPCM] = nonpcm_r;
        rdat[biphase_rx_pkg::STAT_EMPHASIS] = emphasis_r;
        rdat[biphase_rx_pkg::STAT_SRC_REF] = use_ref;
      end
      biphase_rx_pkg::ADR_MEAS: rdat[CNT_W-1:0] = meas_last_r;
      default: rdat = 32'h00000000;
    endcase
  end

  // Classic single-cycle slave: ack one cycle after the strobe, unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      mode_r <= biphase_rx_pkg::CTRL_RST;
    end else if (ce_i) begin
      ack_r <= wb_cyc_i & wb_stb_i & ~ack_r;
      if (wb_cyc_i && wb_stb_i && !ack_r) begin
        dat_r <= rdat;
        if (wb_we_i && wb_sel_i[0] && wb_adr_i == biphase_rx_pkg::ADR_CTRL) begin
          mode_r <= wb_dat_i[biphase_rx_pkg::CTRL_MODE_LSB +: 2];
        end
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  // Flag, error and pulse outputs do not depend on mode; sample, source and clock outputs do.
  assign error_o = err_r;
  assign clock_transition_pulse_o = ct_r;
  assign block_start_out_o = lock_r & (bpulse_r != 4'h0);
  assign nonpcm_flag_o = nonpcm_r;
  assign emphasis_flag_out_o = emphasis_r;
  assign sample_o = sample_r;
  assign sample_valid_o = valid_r;
  assign sample_left_o = sleft_r;
  assign clk_src_ref_o = use_ref;
  assign frame_rate_clock_o = fclk_r;
  assign ref_bit_clock_o = bclk_r;

  AST_NPCM_AT_BLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && !blk_take |=> $stable(nonpcm_r) || !lock_r)
    else $error("non-PCM flag moved outside block start");

  AST_EMPHASIS_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && blk_take && lock_nxt |=> emphasis_r == $past(sh_emphasis_r))
    else $error("emphasis flag not loaded from shadow");

  AST_CODING_UNLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && coding_err_i |=> !lock_r && err_r)
    else $error("coding error did not drop lock");

  AST_PREAMBLE_UNLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && preamble_err_i |=> !lock_r)
    else $error("missing preamble did not drop lock");

  AST_ERR_RISE_CT: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(lock_r) |-> ct_r && err_r)
    else $error("unlock without transition pulse and error");

  AST_ERR_FALL_FRAME: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(err_r) |-> $past(fstb_l) && lock_r)
    else $error("error fell away from a frame edge");

  AST_CONCEAL_PCM: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && frame_stb_i && left_i && parity_err_i && !nonpcm_r && !mute
    |=> sample_r == $past(hold_l_r))
    else $error("PCM parity error not concealed");

  AST_PASS_NONPCM: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && frame_stb_i && parity_err_i && nonpcm_r && !mute |=> sample_r == $past(sample_i))
    else $error("non-PCM data altered on parity error");

  AST_NO_REF_LL: assert property (@(posedge clk_i) disable iff (rst_i)
    !ref_seen_r |-> rate_code_out_o == biphase_rx_pkg::RATE_LL)
    else $error("rate code not LL without reference");

  AST_UNLOCK_HL: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_seen_r && !lock_r |-> rate_code_out_o == biphase_rx_pkg::RATE_HL)
    else $error("rate code not HL while unlocked");

  AST_REF_MUTE: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && frame_stb_i && mode_r == biphase_rx_pkg::MODE_REF |=> sample_r == 24'h000000)
    else $error("data not muted in reference mode");

endmodule : biphase_rx_status_fs_monitor

// ==== testbench/biphase_tx_model.sv ====
// Behavioural transmitter and decoder front end that feeds the monitor one subframe at a time.
`timescale 1ns/100ps
module biphase_tx_model #(
  parameter int GAP = 15
) (
  input wire logic clk_i,
  output logic pll_lock_o,
  output logic frame_stb_o,
  output logic left_o,
  output logic block_o,
  output logic cs_bit_o,
  output logic parity_err_o,
  output logic coding_err_o,
  output logic preamble_err_o,
  output logic [23:0] sample_o
);
  initial begin
    pll_lock_o = 1'h1;
    frame_stb_o = 1'h0;
    left_o = 1'h0;
    block_o = 1'h0;
    cs_bit_o = 1'h0;
    parity_err_o = 1'h0;
    coding_err_o = 1'h0;
    preamble_err_o = 1'h0;
    sample_o = 24'h0;
  end

  // Qualified lines carry the inverse once the strobe has gone, so stale values never match.
  task automatic send(input logic lft, input logic blk, input logic cs, input logic par,
                      input logic [23:0] smp);
    @(posedge clk_i);
    frame_stb_o <= 1'h1;
    left_o <= lft;
    block_o <= blk;
    cs_bit_o <= cs;
    parity_err_o <= par;
    sample_o <= smp;
    @(posedge clk_i);
    frame_stb_o <= 1'h0;
    left_o <= ~lft;
    block_o <= ~blk;
    cs_bit_o <= ~cs;
    parity_err_o <= ~par;
    sample_o <= ~smp;
    repeat (GAP) @(posedge clk_i);
  endtask : send

  // Sets the carrier lock level and the two line fault levels.
  task automatic link(input logic lock, input logic code, input logic pre);
    @(posedge clk_i);
    pll_lock_o <= lock;
    coding_err_o <= code;
    preamble_err_o <= pre;
  endtask : link
endmodule : biphase_tx_model

// ==== testbench/tb_top.sv ====
// Self-checking bench for the biphase receiver status and rate monitor.
`timescale 1ns/100ps
module tb_top;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic ref_clk = 1'h0;
  logic ref_en = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic ack;
  logic pll, fstb, lft, blk, csb, par, cerr, perr;
  logic [23:0] smp;
  logic [23:0] sample_o;
  logic nonpcm, emphasis_flag_out, error_o, pulse, src_ref, out_en;
  logic svalid, sleft, bstart, fclk, bclk;
  logic [1:0] rate;
  int fails = 0;
  int n_compared = 0;
  int n_pulse = 0;
  int n_valid = 0;
  int n_bclk = 0;

  biphase_tx_model i_biphase_tx_model (.clk_i(clk_i), .pll_lock_o(pll), .frame_stb_o(fstb),
    .left_o(lft), .block_o(blk), .cs_bit_o(csb), .parity_err_o(par), .coding_err_o(cerr),
    .preamble_err_o(perr), .sample_o(smp));

  biphase_rx_status_fs_monitor i_biphase_rx_status_fs_monitor (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'h1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .reference_clock_in_i(ref_clk), .pll_lock_i(pll), .frame_stb_i(fstb), .left_i(lft),
    .block_i(blk), .cs_bit_i(csb), .parity_err_i(par), .coding_err_i(cerr),
    .preamble_err_i(perr), .sample_i(smp), .sample_o(sample_o), .sample_valid_o(svalid),
    .sample_left_o(sleft), .nonpcm_flag_o(nonpcm), .emphasis_flag_out_o(emphasis_flag_out),
    .error_o(error_o), .clock_transition_pulse_o(pulse), .block_start_out_o(bstart),
    .rate_code_out_o(rate), .clk_src_ref_o(src_ref), .clk_out_en_o(out_en),
    .frame_rate_clock_o(fclk), .ref_bit_clock_o(bclk));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // Reference runs only while enabled and rests low otherwise, with a phase offset to clk_i.
  initial begin
    #37;
    forever begin
      #100;
      ref_clk = ref_en ? ~ref_clk : 1'h0;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
  end

  always @(posedge clk_i) begin
    if (pulse === 1'h1) begin
      n_pulse <= n_pulse + 1;
    end
    if (svalid === 1'h1) begin
      n_valid <= n_valid + 1;
    end
    if (bclk === 1'h1) begin
      n_bclk <= n_bclk + 1;
    end
  end

  initial begin
    #1000000;
    fails++;
    conclude();
  end

  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : wb

  // Sends n frames from a block start; right status bits 1 and 3 are the inverse of left.
  task automatic blockf(input int n, input logic b1, input logic b3, input logic [23:0] base);
    logic c;
    for (int f = 0; f < n; f++) begin
      c = (f == 1) ? b1 : ((f == 3) ? b3 : 1'h0);
      i_biphase_tx_model.send(1'h1, f == 0, c, 1'h0, base + 24'(f));
      i_biphase_tx_model.send(1'h0, 1'h0, (f == 1 || f == 3) ? ~c : 1'h0, 1'h0, base + 24'(f));
    end
  endtask : blockf

  initial begin
    logic [31:0] q;
    int np;
    wait (rst_i === 1'h0);
    @(posedge clk_i);
    check("error_o", 32'h1, error_o);
    check("rate_code", biphase_rx_pkg::RATE_LL, rate);
    wb(1'h0, biphase_rx_pkg::ADR_STAT, 32'h0, q);
    check("stat", 32'h20, q);
    wb(1'h0, 8'h0C, 32'h0, q);
    check("unmapped", 32'h0, q);
    blockf(8, 1'h0, 1'h0, 24'h100000);
    check("error_o", 32'h0, error_o);
    check("pulses", 32'h1, n_pulse);
    check("valid_count", 32'h10, n_valid);
    check("rate_code", biphase_rx_pkg::RATE_LL, rate);
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h0, 24'h123456);
    i_biphase_tx_model.send(1'h0, 1'h0, 1'h0, 1'h0, 24'h123456);
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h1, 24'hABCDEF);
    check("sample_o", 32'h123456, sample_o);
    check("error_o", 32'h1, error_o);
    check("sample_left", 32'h1, sleft);
    check("block_start", 32'h0, bstart);
    check("frame_clock", 32'h1, fclk);
    blockf(8, 1'h1, 1'h1, 24'h200000);
    check("nonpcm", 32'h0, nonpcm);
    check("emphasis", 32'h0, emphasis_flag_out);
    check("error_o", 32'h0, error_o);
    blockf(8, 1'h0, 1'h0, 24'h300000);
    check("nonpcm", 32'h1, nonpcm);
    check("emphasis", 32'h1, emphasis_flag_out);
    blockf(8, 1'h1, 1'h0, 24'h400000);
    check("nonpcm", 32'h0, nonpcm);
    check("emphasis", 32'h0, emphasis_flag_out);
    blockf(2, 1'h0, 1'h0, 24'h500000);
    check("nonpcm", 32'h1, nonpcm);
    check("emphasis", 32'h0, emphasis_flag_out);
    check("block_start", 32'h1, bstart);
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h1, 24'h55AA33);
    check("sample_o", 32'h55AA33, sample_o);
    ref_en = 1'h1;
    blockf(8, 1'h0, 1'h0, 24'h600000);
    check("rate_code", biphase_rx_pkg::RATE_HL, rate);
    wb(1'h0, biphase_rx_pkg::ADR_STAT, 32'h0, q);
    check("stat", 32'h1E, q & 32'h1F);
    check("bclk_count", 32'h0, n_bclk);
    ref_en = 1'h0;
    repeat (100) @(posedge clk_i);
    check("rate_code", biphase_rx_pkg::RATE_HL, rate);
    wb(1'h0, biphase_rx_pkg::ADR_STAT, 32'h0, q);
    check("stat", 32'h16, q & 32'h1F);
    ref_en = 1'h1;
    wb(1'h1, biphase_rx_pkg::ADR_CTRL, 32'h1, q);
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h0, 24'h777777);
    check("clk_src_ref", 32'h1, src_ref);
    check("sample_o", 32'h0, sample_o);
    check("error_o", 32'h0, error_o);
    repeat (40) @(posedge clk_i);
    check("bclk_seen", 32'h1, 32'(n_bclk != 0));
    ref_en = 1'h0;
    repeat (100) @(posedge clk_i);
    check("clk_out_en", 32'h0, out_en);
    check("bclk_off", 32'h0, bclk);
    ref_en = 1'h1;
    repeat (20) @(posedge clk_i);
    check("clk_out_en", 32'h1, out_en);
    wb(1'h1, biphase_rx_pkg::ADR_CTRL, 32'h2, q);
    check("clk_src_ref", 32'h0, src_ref);
    for (int k = 0; k < 3; k++) begin
      np = n_pulse;
      i_biphase_tx_model.link(k != 2, k == 0, k == 1);
      repeat (8) @(posedge clk_i);
      check("error_o", 32'h1, error_o);
      check("clk_src_ref", 32'h1, src_ref);
      check("rate_code", biphase_rx_pkg::RATE_HL, rate);
      check("pulses", np + 1, n_pulse);
      i_biphase_tx_model.link(1'h1, 1'h0, 1'h0);
      blockf(8, 1'h0, 1'h0, 24'h700000);
      check("error_o", 32'h0, error_o);
      check("clk_src_ref", 32'h0, src_ref);
    end
    wb(1'h1, biphase_rx_pkg::ADR_CTRL, 32'h3, q);
    check("clk_src_ref", 32'h0, src_ref);
    // Left strobes 4096 clocks apart hold about 512 reference edges: the 48 kHz window.
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h0, 24'h010101);
    i_biphase_tx_model.send(1'h0, 1'h0, 1'h0, 1'h0, 24'h010101);
    repeat (4062) @(posedge clk_i);
    i_biphase_tx_model.send(1'h1, 1'h0, 1'h0, 1'h0, 24'h020202);
    check("rate_code", biphase_rx_pkg::RATE_LH, rate);
    wb(1'h0, biphase_rx_pkg::ADR_MEAS, 32'h0, q);
    np = int'(q);
    check("meas_lo", 32'h1, 32'(np >= biphase_rx_pkg::CNT48_MIN));
    check("meas_hi", 32'h1, 32'(np <= biphase_rx_pkg::CNT48_MAX));
    ref_en = 1'h0;
    repeat (100) @(posedge clk_i);
    check("rate_code", biphase_rx_pkg::RATE_LH, rate);
    ref_en = 1'h1;
    rst_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (30) @(posedge clk_i);
    check("error_o", 32'h1, error_o);
    check("rate_code", biphase_rx_pkg::RATE_HL, rate);
    wb(1'h0, biphase_rx_pkg::ADR_CTRL, 32'h0, q);
    check("ctrl", 32'h0, q);
    conclude();
  end
endmodule : tb_top
